// >>> hdl/adcf_bank.sv
// Converter digital filter bank with input mode control and register port
//
// How it works
// - Disabled filter stops, ready flag forced low
// - Full width: 16 bits, else 12 plus zeros
// - Full width matters only averaging with fractional
// - Mode bit: set averages, clear oversamples
// - Codes 000-011: 4..256 samples, shift 1..4
// - Codes 100-111: 2..128 samples, shift 0..3
// - Averaging codes average 2 to 256 samples
// - Interrupt enable routes ready flag to request
// - Differential bit pairs input with shared negative
// - Signed bit selects signed result format
// - Mode register 3 bits 1:0 read zero
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
module adcf_bank
    import adcf_pkg::*;
(
    input  wire logic                          i_clk,
    input  wire logic                          i_nrst,
    input  wire logic [adcf_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    input  wire adcf_pkg::adcf_conv_s          i_conv,
    output logic [31:0]                        o_rdata,
    output logic [adcf_pkg::NUM_MODE_IN-1:0]   o_differential_select,
    output logic [adcf_pkg::NUM_MODE_IN-1:0]   o_signed_output_select,
    output logic [adcf_pkg::NUM_FILTERS-1:0]   o_filter_irq,
    output logic                               o_irq
);
    import adcf_pkg::*;

    // Software-visible state
    logic [31:0]            imode3_reg;           // Input mode control 3
    logic [31:0]            flt_ctl_reg [NUM_FILTERS]; // Writable filter control fields
    logic [NUM_FILTERS-1:0] ready_reg;            // Result ready flags
    logic                   fractional_output_select_reg;            // Fractional output formatting

    // Per-filter wiring
    adcf_ctl_s              ctl      [NUM_FILTERS]; // Control fields for each instance
    logic [15:0]            result   [NUM_FILTERS]; // Latest result of each instance
    logic [NUM_FILTERS-1:0] done;                 // Result completion pulses
    logic [NUM_FILTERS-1:0] rd_flt;               // Filter word read this cycle
    logic [NUM_FILTERS-1:0] wr_flt;               // Filter word written this cycle

    // Interrupt block
    logic [NUM_FILTERS-1:0] irq_status;           // Sticky events
    logic [NUM_FILTERS-1:0] irq_mask;             // Event mask
    logic                   wr_irq_st;            // Status write strobe
    logic                   wr_irq_msk;           // Mask write strobe

    // Read path
    logic [31:0]            rdata_next;           // Word selected by the read address
    logic [31:0]            filter_word [NUM_FILTERS]; // Assembled filter words

    // Decode of one filter word address
    function automatic logic hits_filter(input logic [ADDR_W-1:0] addr, input int idx);
        return addr == ADDR_W'(ADDR_FLT0 + 8'(4 * idx));
    endfunction

    // Strobe decode for the interrupt registers
    assign wr_irq_st  = i_wr && (i_addr == ADDR_IRQ_ST);
    assign wr_irq_msk = i_wr && (i_addr == ADDR_IRQ_MSK);

    // Input mode control 3; the two unimplemented low bits never store
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            imode3_reg <= RST_IMODE3;
        end else if (i_wr && (i_addr == ADDR_IMODE3)) begin
            imode3_reg <= i_wdata & IMODE3_MASK;
        end
    end

    // Configuration word holding the fractional format choice
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fractional_output_select_reg <= RST_CONFIG[CFG_FRACTIONAL_OUTPUT_SELECT];
        end else if (i_wr && (i_addr == ADDR_CONFIG)) begin
            fractional_output_select_reg <= i_wdata[CFG_FRACTIONAL_OUTPUT_SELECT];
        end
    end

    // Mode pins toward the analog front end, split from the stored word
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_differential_select  <= '0;
            o_signed_output_select <= '0;
        end else begin
            for (int k = 0; k < NUM_MODE_IN; k++) begin
                // Odd bit pairs input with the shared negative input
                o_differential_select[k]  <= imode3_reg[IMODE3_LSB + 2 * k + 1];
                // Even bit picks signed result coding
                o_signed_output_select[k] <= imode3_reg[IMODE3_LSB + 2 * k];
            end
        end
    end

    // Filter instances, one control word each
    for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_flt
        // Address hits for this word
        assign wr_flt[g] = i_wr && hits_filter(i_addr, g);
        assign rd_flt[g] = i_rd && hits_filter(i_addr, g);

        // Writable control fields only; ready and result are read-only
        always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                flt_ctl_reg[g] <= RST_FLT;
            end else if (wr_flt[g]) begin
                flt_ctl_reg[g] <= i_wdata & FLT_WR_MASK;
            end
        end

        // Unpack control fields into the carrier
        assign ctl[g].enable     = flt_ctl_reg[g][FLT_ENABLE];
        assign ctl[g].full_width = flt_ctl_reg[g][FLT_FULLW];
        assign ctl[g].mode       = adcf_mode_e'(flt_ctl_reg[g][FLT_MODE]);
        assign ctl[g].ratio      = flt_ctl_reg[g][FLT_RATIO +: 3];
        assign ctl[g].chan       = flt_ctl_reg[g][FLT_CHAN +: 5];

        // Ready flag: disable forces it low, completion beats a same-cycle read
        always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                ready_reg[g] <= 1'b0;
            end else if (!ctl[g].enable) begin
                ready_reg[g] <= 1'b0;
            end else if (done[g]) begin
                ready_reg[g] <= 1'b1;
            end else if (rd_flt[g]) begin
                ready_reg[g] <= 1'b0;
            end
        end

        // Word seen by software
        assign filter_word[g] = {flt_ctl_reg[g][31:25], ready_reg[g],
                                 flt_ctl_reg[g][23:16], result[g]};

        adcf_filter u_filter (
            .i_clk    (i_clk),
            .i_nrst   (i_nrst),
            .i_ctl    (ctl[g]),
            .i_fractional_output_select  (fractional_output_select_reg),
            .i_conv   (i_conv),
            .o_done   (done[g]),
            .o_result (result[g])
        );
    end

    // Per-filter request follows its ready flag when enabled
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_filter_irq <= '0;
        end else begin
            for (int k = 0; k < NUM_FILTERS; k++) begin
                o_filter_irq[k] <= ready_reg[k] && flt_ctl_reg[k][FLT_IRQEN];
            end
        end
    end

    // Completion events feed the sticky status and combined interrupt
    adcf_irq u_irq (
        .i_clk       (i_clk),
        .i_nrst      (i_nrst),
        .i_event     (done),
        .i_wr_status (wr_irq_st),
        .i_wr_mask   (wr_irq_msk),
        .i_wdata     (i_wdata[NUM_FILTERS-1:0]),
        .o_status    (irq_status),
        .o_mask      (irq_mask),
        .o_irq       (o_irq)
    );

    // Read selection; unmapped addresses answer zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (i_addr == ADDR_IMODE3) begin
            rdata_next = imode3_reg & IMODE3_MASK;
        end else if (i_addr == ADDR_CONFIG) begin
            rdata_next[CFG_FRACTIONAL_OUTPUT_SELECT] = fractional_output_select_reg;
        end else if (i_addr == ADDR_IRQ_ST) begin
            rdata_next[NUM_FILTERS-1:0] = irq_status;
        end else if (i_addr == ADDR_IRQ_MSK) begin
            rdata_next[NUM_FILTERS-1:0] = irq_mask;
        end else begin
            for (int k = 0; k < NUM_FILTERS; k++) begin
                if (hits_filter(i_addr, k)) begin
                    rdata_next = filter_word[k];
                end
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

endmodule // adcf_bank

// >>> hdl/adcf_filter.sv
// One accumulate-and-shift filter instance
`timescale 1ns/10ps
module adcf_filter
    import adcf_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_nrst,
    input  wire adcf_pkg::adcf_ctl_s  i_ctl,
    input  wire logic                i_fractional_output_select,
    input  wire adcf_pkg::adcf_conv_s i_conv,
    output logic                     o_done,
    output logic [15:0]              o_result
);
    import adcf_pkg::*;

    logic [ACC_W-1:0] acc_reg;                    // Running sum
    logic [8:0]       cnt_reg;                    // Samples taken so far
    logic [3:0]       lg;                         // Log2 of samples per result
    logic [8:0]       target;                     // Samples per result
    logic [ACC_W-1:0] sum;                        // Sum including this sample
    logic [ACC_W+3:0] wide;                       // Sum with four guard bits
    logic [15:0]      shaped;                     // Formatted result
    logic             take;                       // Sample belongs to this filter

    // Only results from the programmed channel are taken
    assign take   = i_ctl.enable && i_conv.valid && (i_conv.chan == {1'b0, i_ctl.chan});
    assign lg     = adcf_log2_count(i_ctl.mode, i_ctl.ratio);
    assign target = 9'(1) << lg;
    assign sum    = acc_reg + ACC_W'(i_conv.data);
    assign wide   = {sum, 4'h0};

    // Result shaping by mode and output format
    always_comb begin
        if (i_ctl.mode == ADCF_OVERSAMPLE) begin
            // x.1 codes shift by the low code bits, integer codes one further
            shaped = 16'(sum >> (i_ctl.ratio[2] ? {2'b00, i_ctl.ratio[1:0]}
                                                : {2'b00, i_ctl.ratio[1:0]} + 4'h1));
        end else if (i_fractional_output_select) begin
            // Fractional average keeps four extra bits below the integer part
            shaped = 16'(wide >> lg);
            if (!i_ctl.full_width) begin
                shaped = shaped & HI12_MASK;
            end
        end else begin
            shaped = 16'(sum >> lg);
        end
    end

    // Accumulator and sample counter; disabling discards partial sums
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_reg <= '0;
            cnt_reg <= '0;
        end else if (!i_ctl.enable) begin
            acc_reg <= '0;
            cnt_reg <= '0;
        end else if (take) begin
            if (cnt_reg + 9'h001 >= target) begin
                acc_reg <= '0;
                cnt_reg <= '0;
            end else begin
                acc_reg <= sum;
                cnt_reg <= cnt_reg + 9'h001;
            end
        end
    end

    // Result load and completion pulse
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_done   <= 1'b0;
            o_result <= 16'h0000;
        end else begin
            o_done <= take && (cnt_reg + 9'h001 >= target);
            if (take && (cnt_reg + 9'h001 >= target)) begin
                o_result <= shaped;
            end
        end
    end

endmodule // adcf_filter

// >>> hdl/adcf_irq.sv
// Sticky event status, mask and the single level interrupt
`timescale 1ns/10ps
module adcf_irq
    import adcf_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_nrst,
    input  wire logic [NUM_FILTERS-1:0] i_event,
    input  wire logic                   i_wr_status,
    input  wire logic                   i_wr_mask,
    input  wire logic [NUM_FILTERS-1:0] i_wdata,
    output logic [NUM_FILTERS-1:0]      o_status,
    output logic [NUM_FILTERS-1:0]      o_mask,
    output logic                        o_irq
);
    import adcf_pkg::*;

    // Status bits: a new event wins over a same-cycle write-one clear
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status <= RST_IRQ;
        end else begin
            o_status <= (o_status & ~(i_wr_status ? i_wdata : RST_IRQ)) | i_event;
        end
    end

    // Mask register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mask <= RST_IRQ;
        end else if (i_wr_mask) begin
            o_mask <= i_wdata;
        end
    end

    // Level interrupt, one cycle behind the status it reflects
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(o_status & o_mask);
        end
    end

endmodule // adcf_irq

// >>> hdl/adcf_pkg.sv
// Shared constants, field layouts and carrier types of the converter filter bank
package adcf_pkg;

    // Bank geometry
    localparam int NUM_FILTERS  = 6;              // Filter instances in the bank
    localparam int NUM_MODE_IN  = 7;              // Inputs covered by mode register 3
    localparam int SAMPLE_W     = 12;             // Raw conversion width
    localparam int ACC_W        = 20;             // Holds 256 full-scale samples
    localparam int RESULT_W     = 16;             // Filter result field width
    localparam int CHAN_W       = 6;              // Channel number on the result stream
    localparam int ADDR_W       = 8;              // Register port address width

    // Register byte addresses
    localparam logic [7:0] ADDR_IMODE3  = 8'h00;  // Input mode control 3
    localparam logic [7:0] ADDR_FLT0    = 8'h04;  // First filter control, one word each
    localparam logic [7:0] ADDR_CONFIG  = 8'h1C;  // Output format configuration
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h20;  // Sticky event status, write one clears
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h24;  // Event mask

    // Reset values
    localparam logic [31:0] RST_IMODE3  = 32'h0000_0000;
    localparam logic [31:0] RST_FLT     = 32'h0000_0000;
    localparam logic [31:0] RST_CONFIG  = 32'h0000_0000;
    localparam logic [5:0]  RST_IRQ     = 6'h00;

    // Input mode control 3: bits 15:2 implemented, 1:0 read zero
    localparam logic [31:0] IMODE3_MASK = 32'h0000_FFFC;
    localparam int IMODE3_LSB  = 2;               // Input 33 signed bit, pairs upward

    // Filter control word layout
    localparam int FLT_ENABLE  = 31;
    localparam int FLT_FULLW   = 30;
    localparam int FLT_MODE    = 29;
    localparam int FLT_RATIO   = 26;              // Three bits, 28:26
    localparam int FLT_IRQEN   = 25;
    localparam int FLT_READY   = 24;
    localparam int FLT_CHAN    = 16;              // Five bits, 20:16
    localparam logic [31:0] FLT_WR_MASK = 32'hFE1F_0000;

    // Configuration word layout
    localparam int CFG_FRACTIONAL_OUTPUT_SELECT   = 0;

    // Low result bits cleared when only twelve bits are significant
    localparam logic [15:0] HI12_MASK = 16'hFFF0;

    // Filter operating modes
    typedef enum logic {
        ADCF_OVERSAMPLE = 1'b0,
        ADCF_AVERAGE    = 1'b1
    } adcf_mode_e;

    // Control fields handed to one filter instance
    typedef struct packed {
        logic       enable;
        logic       full_width;
        adcf_mode_e mode;
        logic [2:0] ratio;
        logic [4:0] chan;
    } adcf_ctl_s;

    // One conversion result from the converter core
    typedef struct packed {
        logic                valid;
        logic [CHAN_W-1:0]   chan;
        logic [SAMPLE_W-1:0] data;
    } adcf_conv_s;

    // Log2 of the number of samples taken per result
    function automatic logic [3:0] adcf_log2_count(input adcf_mode_e mode,
                                                   input logic [2:0] ratio);
        if (mode == ADCF_AVERAGE) begin
            return {1'b0, ratio} + 4'h1;
        end
        return {1'b0, ratio[1:0], ~ratio[2]} + 4'h1;
    endfunction

endpackage

// >>> tb/adcf_bank_monitor.sv
// Port-level assertion checker for the converter filter bank
`timescale 1ns/10ps
module adcf_bank_monitor
    import adcf_pkg::*;
(
    input  wire logic                               i_clk,
    input  wire logic                               i_nrst,
    input  wire logic [adcf_pkg::ADDR_W-1:0]        i_addr,
    input  wire logic [31:0]                        i_wdata,
    input  wire logic                               i_wr,
    input  wire logic                               i_rd,
    input  wire adcf_pkg::adcf_conv_s               i_conv,
    input  wire logic [31:0]                        o_rdata,
    input  wire logic [adcf_pkg::NUM_MODE_IN-1:0]   o_differential_select,
    input  wire logic [adcf_pkg::NUM_MODE_IN-1:0]   o_signed_output_select,
    input  wire logic [adcf_pkg::NUM_FILTERS-1:0]   o_filter_irq,
    input  wire logic                               o_irq
);
    import adcf_pkg::*;
    logic [31:0] imode_q;   // Shadow of mode register 3
    logic [6:0]  diff_exp;  // Expected pairing selects
    logic [6:0]  sign_exp;  // Expected format selects
    logic        flt_hit;   // Address is a filter word
    logic [2:0]  flt_idx;   // Filter addressed
    assign flt_hit = i_addr >= ADDR_FLT0 && i_addr < ADDR_CONFIG && i_addr[1:0] == 2'b00;
    assign flt_idx = 3'((i_addr - ADDR_FLT0) >> 2);
    // Odd bits choose pairing, even bits choose format
    always_comb begin
        for (int k = 0; k < NUM_MODE_IN; k++) begin
            diff_exp[k] = imode_q[2*k+3];
            sign_exp[k] = imode_q[2*k+2];
        end
    end
    // Shadow kept from the bus so read-back can be predicted
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            imode_q <= 32'h0000_0000;
        end else if (i_wr && i_addr == ADDR_IMODE3) begin
            imode_q <= i_wdata & IMODE3_MASK;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_rdata_idle;
        !i_rd |=> o_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_imode_read;
        i_rd && i_addr == ADDR_IMODE3 |=> o_rdata == imode_q;
    endproperty
    a_imode_read: assert property (p_imode_read) else $error("mode reg readback");
    property p_imode_out;
        imode_q == $past(imode_q) |-> o_differential_select == diff_exp
            && o_signed_output_select == sign_exp;
    endproperty
    a_imode_out: assert property (p_imode_out) else $error("mode select outputs");
    property p_unmapped;
        i_rd && i_addr > ADDR_IRQ_MSK |=> o_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq_regs;
        i_rd && (i_addr == ADDR_IRQ_ST || i_addr == ADDR_IRQ_MSK) |=> o_rdata[31:6] == 26'h0;
    endproperty
    a_irq_regs: assert property (p_irq_regs) else $error("irq reg high bits");
    property p_mask_off;
        i_wr && i_addr == ADDR_IRQ_MSK && i_wdata[5:0] == 6'h00
            ##1 (!(i_wr && i_addr == ADDR_IRQ_MSK)) [*2] |=> !o_irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq still high");
    property p_disable_drop;
        i_wr && flt_hit && !i_wdata[FLT_ENABLE]
            ##1 (!(i_wr && flt_hit)) [*2] |=> !o_filter_irq[$past(flt_idx, 3)];
    endproperty
    a_disable_drop: assert property (p_disable_drop) else $error("disabled filter req");
    property p_req_cause;
        (o_filter_irq & ~$past(o_filter_irq)) != 6'h00 |-> $past(i_conv.valid, 3) || $past(i_wr, 2);
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("request without cause");
    property p_irq_cause;
        $rose(o_irq) |-> $past(i_conv.valid, 3) || $past(i_wr, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule // adcf_bank_monitor

// >>> tb/tb_adcf_bank.sv
// Self-checking random bench for the converter filter bank
`timescale 1ns/10ps
module tb_adcf_bank;
    import adcf_pkg::*;
    logic        i_clk  = 1'b0;  // 25 MHz bank clock
    logic        i_nrst = 1'b0;  // Async reset, low active
    logic [7:0]  i_addr = 8'h00; // Register address
    logic [31:0] i_wdata = 32'h0000_0000;
    logic        i_wr = 1'b0;    // Write strobe
    logic        i_rd = 1'b0;    // Read strobe
    adcf_conv_s  i_conv = '0;    // Conversion stream
    logic [31:0] o_rdata;
    logic [6:0]  o_differential_select;
    logic [6:0]  o_signed_output_select;
    logic [5:0]  o_filter_irq;
    logic        o_irq;
    int          err_count = 0;
    int          check_count = 0;
    // Free-running clock, 40 ns period
    always #20 i_clk = ~i_clk;
    adcf_bank i_adcf_bank (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_conv(i_conv), .o_rdata(o_rdata),
        .o_differential_select(o_differential_select),
        .o_signed_output_select(o_signed_output_select), .o_filter_irq(o_filter_irq),
        .o_irq(o_irq));
    // Compare one word; unknowns never match
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Compare one flag
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask
    // Single exit point of the run
    task automatic final_report();
        $display("Summary: %0d checks, %0d mismatches", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // One-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Back-to-back samples; foreign channels are slipped in and must be ignored
    task automatic feed(input int n, input logic [5:0] ch, output logic [31:0] sum);
        logic [11:0] d;
        sum = 0;
        while (n > 0) begin
            @(posedge i_clk);
            d = 12'($urandom);
            if ($urandom_range(3) == 0) begin
                i_conv <= '{1'b1, ch ^ 6'h21, d};
            end else begin
                i_conv <= '{1'b1, ch, d};
                sum += d;
                n--;
            end
        end
        @(posedge i_clk);
        i_conv.valid <= 1'b0;
    endtask
    // Samples per result for a mode and ratio code
    function automatic int count_of(input logic avg, input logic [2:0] c);
        if (avg) return 1 << (c + 1);
        return c[2] ? 1 << (2 * c[1:0] + 1) : 1 << (2 * c[1:0] + 2);
    endfunction
    // Expected result from the sum of accepted samples
    function automatic logic [15:0] exp_res(input logic avg, input logic [2:0] c, input logic fr,
                                            input logic fw, input logic [31:0] s);
        logic [31:0] r;
        if (!avg) begin
            r = c[2] ? s >> c[1:0] : s >> (c[1:0] + 1);
        end else if (fr) begin
            r = (s << 4) >> (c + 1);
            if (!fw) r[3:0] = 4'h0;
        end else begin
            r = s >> (c + 1);
        end
        return r[15:0];
    endfunction
    // Main sequence
    initial begin
        logic [31:0] d, s, v;
        logic [15:0] res;
        logic [6:0]  ds, ss;
        logic        avg, fr, fw;
        logic [2:0]  c;
        logic [5:0]  ch;
        logic [7:0]  fa;
        int          f, n;
        s = $urandom(32'h3462_dace);
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(ADDR_IMODE3, d);
        chk_word(d, RST_IMODE3, "mode reg reset");
        rd(ADDR_FLT0, d);
        chk_word(d, RST_FLT, "filter reset");
        rd(8'h30, d);
        chk_word(d, 32'h0000_0000, "unmapped read");
        v = $urandom;
        wr(ADDR_IMODE3, v);
        rd(ADDR_IMODE3, d);
        chk_word(d, v & 32'h0000_FFFC, "mode reg readback");
        for (int k = 0; k < 7; k++) begin
            ds[k] = v[2*k+3];
            ss[k] = v[2*k+2];
        end
        chk_word({25'h0, o_differential_select}, {25'h0, ds}, "pairing");
        chk_word({25'h0, o_signed_output_select}, {25'h0, ss}, "format");
        for (int t = 0; t < 20; t++) begin
            f = t % NUM_FILTERS;
            fa = ADDR_FLT0 + 8'(4 * f);
            c = (t < 16) ? 3'(t) : 3'($urandom);
            avg = (t < 16) ? t[3] : 1'($urandom);
            fr = 1'($urandom);
            fw = 1'($urandom);
            ch = {1'b0, 5'($urandom)};
            wr(ADDR_CONFIG, {31'h0, fr});
            wr(ADDR_IRQ_MSK, 32'h0000_003F);
            v = {1'b1, fw, avg, c, 1'b1, 4'h0, ch[4:0], 16'h0000};
            wr(fa, v);
            feed(count_of(avg, c), ch, s);
            res = exp_res(avg, c, fr, fw, s);
            for (n = 0; n < 8 && o_filter_irq[f] !== 1'b1; n++) begin
                @(posedge i_clk);
                #1;
            end
            if (n == 8) begin
                chk_bit(o_filter_irq[f], 1'b1, "request timeout");
                final_report();
            end
            chk_bit(o_irq, 1'b1, "irq after completion");
            rd(ADDR_IRQ_ST, d);
            chk_word(d, 32'h1 << f, "status");
            wr(ADDR_IRQ_MSK, 32'h0000_0000);
            repeat (3) @(posedge i_clk);
            chk_bit(o_irq, 1'b0, "masked irq");
            wr(ADDR_IRQ_ST, 32'h1 << f);
            wr(ADDR_IRQ_MSK, 32'h0000_003F);
            repeat (3) @(posedge i_clk);
            chk_bit(o_irq, 1'b0, "cleared irq");
            if (t % 2 == 0) begin
                rd(fa, d);
                chk_word(d, {v[31:25], 1'b1, v[23:16], v[15:0] | res}, "filter word");
                rd(fa, d);
                chk_bit(d[FLT_READY], 1'b0, "ready after read");
            end
            wr(fa, v & 32'h7FFF_FFFF);
            rd(fa, d);
            chk_word(d[15:0], res, "result held");
            chk_bit(d[FLT_READY], 1'b0, "ready when off");
            feed(2, ch, s);
            repeat (4) @(posedge i_clk);
            rd(ADDR_IRQ_ST, d);
            chk_word(d, 32'h0000_0000, "off filter idle");
            $display("Test %0d done: filter %0d mode %0d code %0d", t, f, avg, c);
        end
        final_report();
    end
endmodule // tb_adcf_bank
bind adcf_bank adcf_bank_monitor i_adcf_bank_monitor (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_conv(i_conv),
    .o_rdata(o_rdata), .o_differential_select(o_differential_select),
    .o_signed_output_select(o_signed_output_select), .o_filter_irq(o_filter_irq), .o_irq(o_irq));
